// ### tdmb_bus_if.v
`timescale 1ns/1ns
// Summary of operation
// R01 - Pin picks timing master or slave
// R02 - Two FIFOs toward framer and from deframer
// R03 - Reset gives short frame, 10-bit format
// R04 - One sync per 8 kHz frame
// R05 - Frame holds B1, B2 and two D bits
// R06 - Three bits select the five formats
// R07 - GCI uses one sync, others two
// R08 - GCI exchanges only 2B+D positions
// R09 - No D channel port over this bus
// R10 - Any timeslot enable overrides the format
// R11 - Master bit clock has three rates
// R12 - Two bits choose master clock rate
// R13 - GCI bit spans two clock periods
// R14 - Slave clock kept in range by partner
// R15 - Master drives both syncs together
// R16 - Long frame sync spans the transfer
// R17 - GCI output driven only on 2B+D
// R18 - Partner aligns slave syncs to its clock
// R19 - Separate bit counters per direction
`include "tdmb_defines.vh"
module tdmb_bus_if (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Link pins
  input wire i_master_slave_select,
  input wire i_data_bit_clock,
  output wire o_data_bit_clock,
  output wire o_data_bit_clock_oe,
  input wire i_transmit_frame_sync,
  output wire o_transmit_frame_sync,
  output wire o_transmit_frame_sync_oe,
  input wire i_receive_frame_sync,
  output wire o_receive_frame_sync,
  output wire o_receive_frame_sync_oe,
  input wire i_serial_data_in,
  output wire o_serial_data_out,
  output wire o_serial_data_out_oe,
  // Toward the line framer
  output wire [17:0] o_fr_data,
  output wire o_fr_valid,
  input wire i_fr_ready,
  // From the line deframer
  input wire [17:0] i_df_data,
  input wire i_df_valid,
  output wire o_df_ready
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Bit position within the frame from the period count
  function [8:0] tdmb_pos;
    input [8:0] cnt;
    input lng;
    input gci;
    begin
      if (gci) begin
        tdmb_pos = {1'b0, cnt[8:1]}; // R13
      end else if (lng) begin
        tdmb_pos = cnt; // R16
      end else if (cnt == 9'h000 || cnt == `TDMB_CNT_IDLE) begin
        tdmb_pos = `TDMB_CNT_IDLE;
      end else begin
        tdmb_pos = cnt - 9'h001;
      end
    end
  endfunction

  // Position to word bit: {valid, index}; B1 0-7, B2 8-15, D 16-17
  function [5:0] tdmb_map;
    input [8:0] pos;
    input eight;
    input gci;
    input [2:0] tsen;
    input [17:0] slots;
    reg [8:0] d1;
    reg [8:0] d2;
    reg [8:0] dd;
    begin
      d1 = pos - {2'b00, slots[5:0], 1'b0};
      d2 = pos - {2'b00, slots[11:6], 1'b0};
      dd = pos - {2'b00, slots[17:12], 1'b0};
      tdmb_map = 6'h00;
      if (tsen != 3'b000) begin
        // Timeslot placement wins over every format
        if (tsen[0] && d1 < 9'd8) begin
          tdmb_map = {3'b100, d1[2:0]}; // R10
        end else if (tsen[1] && d2 < 9'd8) begin
          tdmb_map = {3'b101, d2[2:0]}; // R10
        end else if (tsen[2] && dd < 9'd2) begin
          tdmb_map = {5'b11000, dd[0]}; // R10
        end
      end else if (gci) begin
        // Other GCI positions carry nothing for us
        if (pos < `TDMB_POS_B2_GCI_END) begin
          tdmb_map = {1'b1, pos[4:0]}; // R08
        end else if (pos == `TDMB_POS_D1_GCI || pos == `TDMB_POS_D2_GCI) begin
          tdmb_map = {5'b11000, pos[0]}; // R08
        end
      end else if (eight) begin
        if (pos < `TDMB_POS_END8) begin
          tdmb_map = {1'b1, pos[4:0]}; // R05
        end
      end else begin
        if (pos < `TDMB_POS_D1_10) begin
          tdmb_map = {1'b1, pos[4:0]}; // R05
        end else if (pos == `TDMB_POS_D1_10) begin
          tdmb_map = 6'h30;
        end else if (pos >= `TDMB_POS_B2_10 && pos < `TDMB_POS_D2_10) begin
          d1 = pos - 9'd2;
          tdmb_map = {1'b1, d1[4:0]};
        end else if (pos == `TDMB_POS_D2_10) begin
          tdmb_map = 6'h31;
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and APB slave
  // ----------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg [17:0] slot_r;
  reg txovf_r;
  reg rxunf_r;
  reg pready_r;
  reg pslverr_r;
  reg [31:0] prdata_r;
  reg [2:0] tcnt_r;
  reg [2:0] rcnt_r;
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] sync3_r;
  reg [4:0] filt_r;
  wire access = i_psel & i_penable;
  wire done = access & pready_r;
  wire wr = done & i_pwrite;
  wire hit_ctrl = i_paddr == `TDMB_OFS_CTRL;
  wire hit_stat = i_paddr == `TDMB_OFS_STAT;
  wire hit_slot = i_paddr == `TDMB_OFS_SLOT;
  wire is_master = filt_r[0];
  wire eight = ctrl_r[`TDMB_CTRL_EIGHT];
  wire lng = ctrl_r[`TDMB_CTRL_LONG];
  wire [2:0] tsen = ctrl_r[`TDMB_CTRL_TSEN_HI:`TDMB_CTRL_TSEN_LO];
  wire gci = ctrl_r[`TDMB_CTRL_GCI] & (tsen == 3'b000);
  wire tx_ovf_set;
  wire rx_unf_set;

  // One wait state, then ready; write lands on the ready edge
  always @(posedge i_clk) begin
    if (i_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~(hit_ctrl | hit_stat | hit_slot);
      if (access & ~pready_r) begin
        if (i_pwrite || !(hit_ctrl | hit_stat | hit_slot)) begin
          prdata_r <= 32'h00000000;
        end else if (hit_ctrl) begin
          prdata_r <= {24'h000000, ctrl_r};
        end else if (hit_stat) begin
          prdata_r <= {21'h00000, rcnt_r, 1'b0, tcnt_r, 1'b0,
                       is_master, rxunf_r, txovf_r};
        end else begin
          prdata_r <= {10'h000, slot_r[17:12], 2'b00, slot_r[11:6],
                       2'b00, slot_r[5:0]};
        end
      end
    end
  end

  // Control, timeslot and sticky status; a new event beats the clear
  always @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r <= `TDMB_CTRL_RST; // R03
      slot_r <= `TDMB_SLOT_RST;
      txovf_r <= 1'b0;
      rxunf_r <= 1'b0;
    end else begin
      if (wr && hit_ctrl) begin
        if (i_pwdata[`TDMB_CTRL_SRST]) begin
          ctrl_r <= `TDMB_CTRL_RST; // R03
        end else begin
          ctrl_r <= i_pwdata[7:0]; // R06
        end
      end
      if (wr && hit_slot) begin
        slot_r <= {i_pwdata[21:16], i_pwdata[13:8], i_pwdata[5:0]};
      end
      txovf_r <= tx_ovf_set |
                 (txovf_r & ~(wr & hit_stat & i_pwdata[`TDMB_STAT_TXOVF]));
      rxunf_r <= rx_unf_set |
                 (rxunf_r & ~(wr & hit_stat & i_pwdata[`TDMB_STAT_RXUNF]));
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Order: master select, bit clock, tx sync, rx sync, data in
  wire [4:0] pins = {i_serial_data_in, i_receive_frame_sync,
                     i_transmit_frame_sync, i_data_bit_clock,
                     i_master_slave_select};
  // Filtered level moves only when stages two and three agree
  wire [4:0] filt_nxt = (sync2_r & sync3_r) |
                        (filt_r & (sync2_r | sync3_r));
  always @(posedge i_clk) begin
    if (i_rst) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
      filt_r <= 5'h00;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Master bit clock and frame sync generator
  // ----------------------------------------------------------------
  // Fractional step; jitter of one system clock traded for exact mean rate
  wire [63:0] inc_lo = `TDMB_NCO_INC(`TDMB_RATE_LOW_HZ);
  wire [63:0] inc_mid = `TDMB_NCO_INC(`TDMB_RATE_MID_HZ);
  wire [63:0] inc_hi = `TDMB_NCO_INC(`TDMB_RATE_HIGH_HZ);
  wire [31:0] frm_lo = `TDMB_FRM_CLKS(`TDMB_RATE_LOW_HZ);
  wire [31:0] frm_mid = `TDMB_FRM_CLKS(`TDMB_RATE_MID_HZ);
  wire [31:0] frm_hi = `TDMB_FRM_CLKS(`TDMB_RATE_HIGH_HZ);
  reg [31:0] acc_r;
  reg [8:0] mcnt_r;
  reg msync_r;
  reg mdbc_r;
  reg [31:0] inc;
  reg [8:0] frm;
  reg [8:0] sync_len;
  always @* begin
    if (ctrl_r[`TDMB_CTRL_RLOW]) begin
      inc = inc_lo[31:0]; // R12
      frm = frm_lo[8:0];
    end else if (ctrl_r[`TDMB_CTRL_RMID]) begin
      inc = inc_mid[31:0]; // R12
      frm = frm_mid[8:0];
    end else begin
      inc = inc_hi[31:0]; // R12
      frm = frm_hi[8:0];
    end
    if (gci) begin
      sync_len = `TDMB_SYNC_GCI;
    end else if (lng) begin
      sync_len = eight ? `TDMB_SYNC_LONG8 : `TDMB_SYNC_LONG10; // R16
    end else begin
      sync_len = `TDMB_SYNC_SHORT;
    end
  end
  wire [31:0] acc_nxt = acc_r + inc;
  wire m_rise = acc_nxt[31] & ~acc_r[31];
  wire m_fall = ~acc_nxt[31] & acc_r[31];
  wire [8:0] mcnt_nxt = (mcnt_r >= frm - 9'h001) ? 9'h000 : mcnt_r + 9'h001;
  // Frame counter sets the 8 kHz repeat, one sync per frame
  always @(posedge i_clk) begin
    if (i_rst) begin
      acc_r <= 32'h00000000;
      mcnt_r <= 9'h000;
      msync_r <= 1'b0;
      mdbc_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt; // R11
      mdbc_r <= acc_nxt[31];
      if (m_rise) begin
        mcnt_r <= mcnt_nxt; // R04
        msync_r <= mcnt_nxt < sync_len; // R04
      end
    end
  end

  // ----------------------------------------------------------------
  // Link event selection
  // ----------------------------------------------------------------
  // Slave relies on partner clock range and sync alignment (R14, R18)
  wire rise = is_master ? m_rise : (filt_nxt[1] & ~filt_r[1]); // R01
  wire fall = is_master ? m_fall : (~filt_nxt[1] & filt_r[1]); // R01
  wire rx_sync = is_master ? msync_r : filt_r[3]; // R01
  // GCI has a single sync on the receive sync pin
  wire tx_sync = gci ? rx_sync : (is_master ? msync_r : filt_r[2]); // R07

  // ----------------------------------------------------------------
  // Direction counters
  // ----------------------------------------------------------------
  reg [8:0] txc_r;
  reg [8:0] rxc_r;
  reg txprev_r;
  reg rxprev_r;
  wire tx_det = rise & tx_sync & ~txprev_r;
  wire rx_det = rise & rx_sync & ~rxprev_r;
  wire [8:0] rxc_nxt = rx_det ? 9'h000 :
                       (rxc_r == `TDMB_CNT_IDLE) ? rxc_r : rxc_r + 9'h001;
  // Each direction follows its own sync
  always @(posedge i_clk) begin
    if (i_rst) begin
      txc_r <= `TDMB_CNT_IDLE;
      rxc_r <= `TDMB_CNT_IDLE;
      txprev_r <= 1'b0;
      rxprev_r <= 1'b0;
    end else if (rise) begin
      txprev_r <= tx_sync;
      rxprev_r <= rx_sync;
      rxc_r <= rxc_nxt; // R19
      if (tx_det) begin
        txc_r <= 9'h000; // R19
      end else if (txc_r != `TDMB_CNT_IDLE) begin
        txc_r <= txc_r + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit direction: data in toward framer FIFO
  // ----------------------------------------------------------------
  // D bits stay in the main stream; no separate D channel port
  wire [5:0] tx_map = tdmb_map(tdmb_pos(txc_r, lng, gci), eight, gci,
                               tsen, slot_r); // R09
  reg [17:0] txw_r;
  reg txgot_r;
  reg [17:0] tmem_r [0:3];
  reg [1:0] twr_r;
  reg [1:0] trd_r;
  reg [17:0] frd_r;
  reg frv_r;
  wire tpush_req = tx_det & txgot_r;
  wire tfull = tcnt_r == `TDMB_FIFO_DEPTH;
  wire tpush = tpush_req & ~tfull;
  wire tpop = (tcnt_r != 3'd0) & (~frv_r | i_fr_ready);
  assign tx_ovf_set = tpush_req & tfull;
  // GCI samples once, in the second clock of each bit
  always @(posedge i_clk) begin
    if (i_rst) begin
      txw_r <= 18'h00000;
      txgot_r <= 1'b0;
    end else begin
      if (fall && tx_map[5] && (!gci || txc_r[0])) begin
        txw_r[tx_map[4:0]] <= filt_r[4]; // R02
        txgot_r <= 1'b1;
      end else if (tx_det) begin
        txgot_r <= 1'b0;
      end
    end
  end

  // Frame handed over at next sync; output stage adds one slot
  always @(posedge i_clk) begin
    if (i_rst) begin
      twr_r <= 2'b00;
      trd_r <= 2'b00;
      tcnt_r <= 3'd0;
      frd_r <= 18'h00000;
      frv_r <= 1'b0;
    end else begin
      if (tpush) begin
        tmem_r[twr_r] <= txw_r; // R02
        twr_r <= twr_r + 2'b01;
      end
      if (tpop) begin
        frd_r <= tmem_r[trd_r];
        frv_r <= 1'b1;
        trd_r <= trd_r + 2'b01;
      end else if (i_fr_ready) begin
        frv_r <= 1'b0;
      end
      tcnt_r <= tcnt_r + {2'b00, tpush} - {2'b00, tpop};
    end
  end

  // ----------------------------------------------------------------
  // Receive direction: deframer FIFO toward data out
  // ----------------------------------------------------------------
  reg [17:0] rmem_r [0:3];
  reg [1:0] rwr_r;
  reg [1:0] rrd_r;
  reg dfr_r;
  reg [17:0] rxw_r;
  reg sdo_r;
  reg sdo_oe_r;
  wire rpush = i_df_valid & dfr_r;
  wire rpop = rx_det & (rcnt_r != 3'd0);
  assign rx_unf_set = rx_det & (rcnt_r == 3'd0);
  wire [2:0] rcnt_nxt = rcnt_r + {2'b00, rpush} - {2'b00, rpop};
  // Empty FIFO sends idle ones rather than stale data
  wire [17:0] rx_word = rpop ? rmem_r[rrd_r] :
                        rx_det ? `TDMB_IDLE_WORD : rxw_r;
  wire [5:0] rx_map = tdmb_map(tdmb_pos(rxc_nxt, lng, gci), eight, gci,
                               tsen, slot_r);
  always @(posedge i_clk) begin
    if (i_rst) begin
      rwr_r <= 2'b00;
      rrd_r <= 2'b00;
      rcnt_r <= 3'd0;
      dfr_r <= 1'b0;
    end else begin
      if (rpush) begin
        rmem_r[rwr_r] <= i_df_data; // R02
        rwr_r <= rwr_r + 2'b01;
      end
      if (rpop) begin
        rrd_r <= rrd_r + 2'b01;
      end
      rcnt_r <= rcnt_nxt;
      dfr_r <= rcnt_nxt != `TDMB_FIFO_DEPTH;
    end
  end

  // Output changes on bit clock rise; released off the 2B+D slots
  always @(posedge i_clk) begin
    if (i_rst) begin
      rxw_r <= `TDMB_IDLE_WORD;
      sdo_r <= 1'b1;
      sdo_oe_r <= 1'b0;
    end else if (rise) begin
      rxw_r <= rx_word;
      sdo_r <= rx_map[5] ? rx_word[rx_map[4:0]] : 1'b1; // R02
      sdo_oe_r <= rx_map[5]; // R17
    end
  end

  // ----------------------------------------------------------------
  // Link pin drivers
  // ----------------------------------------------------------------
  reg dbc_oe_r;
  reg txfs_r;
  reg txfs_oe_r;
  reg rxfs_r;
  reg rxfs_oe_r;
  // Both syncs from one flop source so they coincide
  always @(posedge i_clk) begin
    if (i_rst) begin
      dbc_oe_r <= 1'b0;
      txfs_r <= 1'b0;
      txfs_oe_r <= 1'b0;
      rxfs_r <= 1'b0;
      rxfs_oe_r <= 1'b0;
    end else begin
      dbc_oe_r <= is_master; // R01
      txfs_r <= msync_r & ~gci; // R15
      rxfs_r <= msync_r; // R15
      txfs_oe_r <= is_master & ~gci; // R07
      rxfs_oe_r <= is_master; // R01
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_data_bit_clock = mdbc_r;
  assign o_data_bit_clock_oe = dbc_oe_r;
  assign o_transmit_frame_sync = txfs_r;
  assign o_transmit_frame_sync_oe = txfs_oe_r;
  assign o_receive_frame_sync = rxfs_r;
  assign o_receive_frame_sync_oe = rxfs_oe_r;
  assign o_serial_data_out = sdo_r;
  assign o_serial_data_out_oe = sdo_oe_r;
  assign o_fr_data = frd_r;
  assign o_fr_valid = frv_r;
  assign o_df_ready = dfr_r;

endmodule

// ### tdmb_bus_if_props.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the highway interface
// ----------------------------------------
module tdmb_bus_if_chk (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire o_pready,
  input wire o_pslverr,
  // Link pins
  input wire o_data_bit_clock,
  input wire o_data_bit_clock_oe,
  input wire o_transmit_frame_sync,
  input wire o_transmit_frame_sync_oe,
  input wire o_receive_frame_sync,
  input wire o_receive_frame_sync_oe,
  // Toward the line framer
  input wire [17:0] o_fr_data,
  input wire o_fr_valid,
  input wire i_fr_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [9:0] rise_cnt_r;
  logic seen_r;
  logic dcl_q_r;
  logic fs_q_r;
  // Bit clock rises per master frame; first frame is partial, so skipped
  always @(posedge i_clk) begin
    if (i_rst || !o_data_bit_clock_oe) begin
      rise_cnt_r <= 10'h000;
      seen_r <= 1'b0;
      dcl_q_r <= 1'b0;
      fs_q_r <= 1'b1;
    end else begin
      dcl_q_r <= o_data_bit_clock;
      fs_q_r <= o_receive_frame_sync;
      if (o_receive_frame_sync && !fs_q_r) begin
        seen_r <= 1'b1;
        rise_cnt_r <= {9'h000, o_data_bit_clock && !dcl_q_r};
      end else if (o_data_bit_clock && !dcl_q_r) begin
        rise_cnt_r <= rise_cnt_r + 10'h001;
      end
    end
  end
  bclk_oe_match_a: assert property (o_data_bit_clock_oe ==
    o_receive_frame_sync_oe) else $error("clock and sync enables differ");
  sync_together_a: assert property (o_transmit_frame_sync_oe |->
    o_receive_frame_sync_oe && o_transmit_frame_sync == o_receive_frame_sync)
    else $error("master syncs not coincident");
  frame_len_a: assert property (o_receive_frame_sync && !fs_q_r &&
    seen_r |-> rise_cnt_r inside {[63:65], [255:257], [319:321]})
    else $error("master frame length wrong");
  fr_hold_a: assert property (o_fr_valid && !i_fr_ready |=>
    o_fr_valid && $stable(o_fr_data)) else $error("framer word dropped");
  pready_time_a: assert property (i_psel && i_penable && !$past(i_penable)
    |=> o_pready) else $error("pready late");
  pready_once_a: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  pready_req_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready without access");
  slverr_pair_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
endmodule
bind tdmb_bus_if tdmb_bus_if_chk u_tdmb_bus_if_chk (.i_clk(i_clk),
  .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_data_bit_clock(o_data_bit_clock),
  .o_data_bit_clock_oe(o_data_bit_clock_oe),
  .o_transmit_frame_sync(o_transmit_frame_sync),
  .o_transmit_frame_sync_oe(o_transmit_frame_sync_oe),
  .o_receive_frame_sync(o_receive_frame_sync),
  .o_receive_frame_sync_oe(o_receive_frame_sync_oe),
  .o_fr_data(o_fr_data), .o_fr_valid(o_fr_valid), .i_fr_ready(i_fr_ready));

// ### tdmb_defines.vh
`ifndef TDMB_DEFINES_VH
`define TDMB_DEFINES_VH
// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define TDMB_CLK_HZ 125000000
`define TDMB_FRAME_HZ 8000
`define TDMB_RATE_LOW_HZ 512000
`define TDMB_RATE_MID_HZ 2048000
`define TDMB_RATE_HIGH_HZ 2560000
// Phase step of the bit clock generator, 32-bit accumulator
`define TDMB_NCO_INC(f) (((64'd1 << 32) * (f)) / `TDMB_CLK_HZ)
// Bit clock periods in one 8 kHz frame
`define TDMB_FRM_CLKS(f) ((f) / `TDMB_FRAME_HZ)
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TDMB_OFS_CTRL 12'h000
`define TDMB_OFS_STAT 12'h004
`define TDMB_OFS_SLOT 12'h008
// ----------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------
`define TDMB_CTRL_EIGHT 0
`define TDMB_CTRL_LONG 1
`define TDMB_CTRL_GCI 2
`define TDMB_CTRL_RLOW 3
`define TDMB_CTRL_RMID 4
`define TDMB_CTRL_TSEN_LO 5
`define TDMB_CTRL_TSEN_HI 7
`define TDMB_CTRL_SRST 31
`define TDMB_CTRL_RST 8'h00
`define TDMB_SLOT_RST 18'h00000
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define TDMB_STAT_TXOVF 0
`define TDMB_STAT_RXUNF 1
`define TDMB_STAT_MASTER 2
// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define TDMB_SYNC_SHORT 9'd1
`define TDMB_SYNC_LONG8 9'd18
`define TDMB_SYNC_LONG10 9'd20
`define TDMB_SYNC_GCI 9'd2
`define TDMB_POS_B2_GCI_END 9'd16
`define TDMB_POS_D1_GCI 9'd24
`define TDMB_POS_D2_GCI 9'd25
`define TDMB_POS_END8 9'd18
`define TDMB_POS_D1_10 9'd8
`define TDMB_POS_B2_10 9'd10
`define TDMB_POS_D2_10 9'd18
`define TDMB_CNT_IDLE 9'h1ff
`define TDMB_IDLE_WORD 18'h3ffff
`define TDMB_FIFO_DEPTH 3'd4
`endif

// ### tdmb_pad_unused.v
`timescale 1ns/1ns

// ### tdmb_partner.sv
`timescale 1ns/1ns
// ----------------------------------------
// Highway master facing a slave device
// ----------------------------------------
module tdmb_partner (
  // Link pins toward the device
  output logic o_dcl,
  output logic o_fsx,
  output logic o_fsr,
  output logic o_din,
  // Device data out
  input wire logic i_sdo,
  input wire logic i_sdo_oe
);
  initial begin
    o_dcl = 1'b0;
    o_fsx = 1'b0;
    o_fsr = 1'b0;
    o_din = 1'b0;
  end
  // Word bit at a frame position, -1 where the frame carries none
  function automatic int bit_of(input int pos, input logic [2:0] f);
    if (f[2])
      return (pos < 16) ? pos : (pos == 24 || pos == 25) ? pos - 8 : -1;
    if (f[0])
      return (pos < 18) ? pos : -1;
    if (pos < 8)
      return pos;
    if (pos == 8)
      return 16;
    if (pos >= 10 && pos < 18)
      return pos - 2;
    return (pos == 18) ? 17 : -1;
  endfunction
  // One frame; clock stands still outside it, unused bits toggle
  task automatic run_frame(input logic [2:0] f, input logic [17:0] w,
    output logic [17:0] rx, output logic bad);
    int np, slen, off, p, b;
    np = f[2] ? 56 : 22;
    slen = f[2] ? 2 : f[1] ? (f[0] ? 18 : 20) : 1;
    off = (f[2] || f[1]) ? 0 : 1;
    rx = 18'h3ffff;
    bad = 1'b0;
    #2;
    o_fsx = 1'b1;
    o_fsr = 1'b1;
    #32;
    for (p = 0; p < np; p++) begin
      b = f[2] ? bit_of(p / 2, f) : (p < off) ? -1 : bit_of(p - off, f);
      o_dcl = 1'b1;
      o_din = (b < 0) ? ~o_din : w[b];
      #32;
      o_dcl = 1'b0;
      if (p + 1 >= slen) begin
        o_fsx = 1'b0;
        o_fsr = 1'b0;
      end
      #24;
      if (b >= 0 && (!f[2] || p[0]))
        rx[b] = i_sdo_oe ? i_sdo : 1'bx;
      if (f[2] && b < 0 && i_sdo_oe)
        bad = 1'b1;
      #8;
    end
    o_din = ~o_din;
  endtask
endmodule

// ### test_tdmb_bus_if.sv
`timescale 1ns/1ns
module test_tdmb_bus_if;
  logic i_clk, i_rst, psel, penable, pwrite, ms, fr_ready, df_valid;
  logic rerr, bad;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdata, rnd, s2, e;
  logic [17:0] df_data, rx, fr_q[$], w[2], d[2];
  logic [2:0] fmt[5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100};
  logic [7:0] rb[3] = '{8'h00, 8'h10, 8'h18};
  int hz[3] = '{2560000, 2048000, 512000};
  int error_cnt = 0, compares = 0, i, k, n;
  longint t0;
  wire [31:0] prdata;
  wire [17:0] fr_data;
  wire pready, pslverr, dcl_o, dcl_oe, fsx_o, fsx_oe, fsr_o, fsr_oe;
  wire sdo, sdo_oe, fr_valid, df_ready, p_dcl, p_fsx, p_fsr, p_din;
  wire dcl_w = dcl_oe ? dcl_o : p_dcl;
  wire fsx_w = fsx_oe ? fsx_o : p_fsx;
  wire fsr_w = fsr_oe ? fsr_o : p_fsr;
  tdmb_bus_if u_tdmb_bus_if (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_master_slave_select(ms),
    .i_data_bit_clock(dcl_w), .o_data_bit_clock(dcl_o),
    .o_data_bit_clock_oe(dcl_oe), .i_transmit_frame_sync(fsx_w),
    .o_transmit_frame_sync(fsx_o), .o_transmit_frame_sync_oe(fsx_oe),
    .i_receive_frame_sync(fsr_w), .o_receive_frame_sync(fsr_o),
    .o_receive_frame_sync_oe(fsr_oe), .i_serial_data_in(p_din),
    .o_serial_data_out(sdo), .o_serial_data_out_oe(sdo_oe),
    .o_fr_data(fr_data), .o_fr_valid(fr_valid), .i_fr_ready(fr_ready),
    .i_df_data(df_data), .i_df_valid(df_valid), .o_df_ready(df_ready));
  tdmb_partner u_tdmb_partner (.o_dcl(p_dcl), .o_fsx(p_fsx), .o_fsr(p_fsr),
    .o_din(p_din), .i_sdo(sdo), .i_sdo_oe(sdo_oe));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    compares++;
    if (g !== ex) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, g);
    end
  endtask
  // APB transfer held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task df_push(input logic [17:0] dw);
    @(posedge i_clk);
    df_valid <= 1'b1;
    df_data <= dw;
    do @(posedge i_clk); while (df_ready !== 1'b1);
    df_valid <= 1'b0;
  endtask
  task stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Clock, framer stalls drawn at random, framer word capture
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    s2 = lfsr(s2);
    fr_ready <= s2[0] | s2[5];
    if (fr_valid === 1'b1 && fr_ready)
      fr_q.push_back(fr_data);
  end
  initial begin
    #700000;
    error_cnt++;
    $display("watchdog expired");
    stop_test;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_clk, psel, penable, pwrite, ms, df_valid} = 6'h00;
    {paddr, pwdata, df_data} = 62'h0;
    i_rst = 1'b1;
    rnd = 32'h870d4cfc;
    s2 = 32'h870d4cfc;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(0, 12'h000, 0);
    chk("ctrl_rst", 0, rdata);
    apb(0, 12'h008, 0);
    chk("slot_rst", 0, rdata);
    apb(0, 12'h00c, 0);
    chk("unmapped_err", 1, rerr);
    chk("unmapped_data", 0, rdata);
    rnd = lfsr(rnd);
    apb(1, 12'h008, rnd);
    apb(0, 12'h008, 0);
    chk("slot_rw", rnd & 32'h003f3f3f, rdata);
    rnd = lfsr(rnd);
    apb(1, 12'h000, rnd & 32'hff);
    apb(0, 12'h000, 0);
    chk("ctrl_rw", rnd & 32'hff, rdata);
    apb(1, 12'h000, 32'h800000ff);
    apb(0, 12'h000, 0);
    chk("ctrl_soft_rst", 0, rdata);
    $display("register test done");
    // Slave frames in each of the five formats
    for (i = 0; i < 5; i++) begin
      apb(1, 12'h000, {29'h0, fmt[i]});
      u_tdmb_partner.run_frame(fmt[i], rnd[17:0], rx, bad);
      repeat (10) @(posedge i_clk);
      for (k = 0; k < 2; k++) begin
        rnd = lfsr(rnd);
        w[k] = rnd[17:0];
        rnd = lfsr(rnd);
        d[k] = rnd[17:0];
        df_push(d[k]);
        u_tdmb_partner.run_frame(fmt[i], w[k], rx, bad);
        if (k == 0) fr_q.delete();
        chk("sdo_word", d[k], rx);
        chk("gci_sdo_idle", 0, bad);
      end
      u_tdmb_partner.run_frame(fmt[i], rnd[17:0], rx, bad);
      repeat (20) @(posedge i_clk);
      chk("fr_count", 2, fr_q.size());
      for (k = 0; k < 2 && k < fr_q.size(); k++)
        chk("fr_word", w[k], fr_q[k]);
      $display("format test %0d done", i);
    end
    apb(0, 12'h004, 0);
    chk("stat_underflow", 1, rdata[1]);
    apb(1, 12'h004, 32'h3);
    apb(0, 12'h004, 0);
    chk("stat_w1c", 0, rdata[1:0]);
    // Master rates, long 8-bit frame sync span
    for (i = 0; i < 3; i++) begin
      apb(1, 12'h000, {24'h0, rb[i] | 8'h03});
      ms <= 1'b1;
      repeat (20) @(posedge i_clk);
      @(posedge dcl_o);
      t0 = $time;
      repeat (32) @(posedge dcl_o);
      t0 = $time - t0;
      e = 64'd32000000000 / hz[i];
      chk("bclk_ns", e, (t0 > e - 16 && t0 < e + 16) ? e : t0);
      apb(0, 12'h004, 0);
      chk("stat_master", 1, rdata[2]);
      if (i == 2) begin
        @(posedge fsx_o);
        n = 0;
        do begin
          @(posedge dcl_o);
          n += fsx_o;
        end while (fsx_o === 1'b1);
        chk("long_sync_len", 18, n);
        @(posedge fsr_o);
        repeat (4) @(posedge i_clk);
      end
      ms <= 1'b0;
      repeat (20) @(posedge i_clk);
      $display("master rate test %0d done", i);
    end
    stop_test;
  end
endmodule
